/* logic/adcpm_pkg.sv */
// Shared constants and state type for the converter power mode sequencer.
// What this block does
// - Two power states chosen at select release.
// - Select fall samples input, starts conversion in normal state.
// - Release after tenth edge, before sixteenth: powered, aborted, idle.
// - Release between edges two and ten: power-down.
// - Release before second edge: stay normal.
// - Power-down turns all analog circuitry off.
// - Select fall wakes; up after sixteen clocks.
// - Early release during wake returns to power-down.
// - Power-up within one microsecond; dummy frame.
// - Wake: track at first edge after fall.
// - Start state after supply is either one.
// - Track-and-hold tracks after initial power-up.
// - Result MSB first, 16-bit, zero padded.
// - Select fall drives first zero; edges shift.
// - Output released at sixteenth falling edge.
package adcpm_pkg;

  localparam int          CNT_W          = 5;
  localparam logic [4:0]  FRAME_EDGES    = 5'h10;
  localparam logic [4:0]  GLITCH_EDGES   = 5'h02;
  localparam logic [4:0]  KEEP_EDGES     = 5'h0A;
  localparam logic [4:0]  TRACK_EDGES    = 5'h0D;
  localparam logic [3:0]  LEAD_ZEROS     = 4'h0;
  localparam int          MAX_RES_BITS   = 12;

  // Flag positions of the per-frame edge flags.
  localparam int          FL_FIRST       = 0;
  localparam int          FL_GLITCH      = 1;
  localparam int          FL_KEEP        = 2;
  localparam int          FL_TRACK       = 3;
  localparam int          FL_CONV        = 4;
  localparam int          FL_FULL        = 5;
  localparam int          FL_W           = 6;

  localparam int          CLK_MHZ        = 50;
  localparam int          POWERUP_NS     = 1000;
  localparam int          POWERUP_CYCLES = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int          SETTLE_W       = 7;

  localparam logic        START_POWERED  = 1'b1;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_DOWN   = 2'b01,
    PWR_WAKE   = 2'b10
  } adcpm_state_t;

endpackage : adcpm_pkg

/* logic/adcpm_sync.sv */
// Two flip-flop level synchroniser for a group of independent levels.
`timescale 1ns/10ps
module adcpm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,      // Destination clock.
  input  wire logic             rst,      // Synchronous reset, active high.
  input  wire logic [WIDTH-1:0] rst_val,  // Value taken during reset.
  input  wire logic [WIDTH-1:0] d,        // Levels from another domain.
  output logic      [WIDTH-1:0] q         // Synchronised levels.
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= rst_val;
      q      <= rst_val;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule : adcpm_sync

/* logic/adcpm_link.sv */
// Bit-clock side: falling edge counter, frame flags and result shifter.
`timescale 1ns/10ps
module adcpm_link #(
  parameter int RES_BITS = 12
) (
  input  wire logic                bit_clk,           // Serial bit clock.
  input  wire logic                frame_select_n,    // Frame select pin.
  input  wire logic [RES_BITS-1:0] conversion_result, // Converter result.
  output logic                     serial_result_out, // Serial data bit.
  output logic                     serial_result_oe,  // Data pin enable.
  output logic [adcpm_pkg::FL_W-1:0] edge_flags       // Per-frame levels.
);

  localparam int          PAD       = adcpm_pkg::MAX_RES_BITS - RES_BITS;
  localparam logic [4:0]  CONV_EDGES = 5'(RES_BITS + 4);

  logic [adcpm_pkg::CNT_W-1:0] edge_cnt;
  logic [11:0]                 res_left;
  logic [15:0]                 word;
  logic                        next_bit;
  logic                        at_end;

  assign res_left = 12'(conversion_result) << PAD;
  assign word     = {adcpm_pkg::LEAD_ZEROS, res_left};
  assign at_end   = (edge_cnt == adcpm_pkg::FRAME_EDGES);
  assign next_bit = (edge_cnt < 5'h0F) ? word[4'(5'h0E - edge_cnt)] : 1'b0;

  // The select level clears the count, so each frame starts from zero.
  always_ff @(negedge bit_clk or posedge frame_select_n) begin
    if (frame_select_n) begin
      edge_cnt <= '0;
    end else if (!at_end) begin
      edge_cnt <= edge_cnt + 5'h01;
    end
  end

  // The first leading zero stands from the select fall on.
  always_ff @(negedge bit_clk or posedge frame_select_n) begin
    if (frame_select_n) begin
      serial_result_out <= 1'b0;
    end else begin
      serial_result_out <= next_bit;
    end
  end

  // Released at the sixteenth edge or at once when select rises.
  assign serial_result_oe = !frame_select_n && !at_end;

  assign edge_flags[adcpm_pkg::FL_FIRST]  = (edge_cnt != 5'h00);
  assign edge_flags[adcpm_pkg::FL_GLITCH] =
    (edge_cnt >= adcpm_pkg::GLITCH_EDGES);
  assign edge_flags[adcpm_pkg::FL_KEEP]   =
    (edge_cnt >= adcpm_pkg::KEEP_EDGES);
  assign edge_flags[adcpm_pkg::FL_TRACK]  =
    (edge_cnt >= adcpm_pkg::TRACK_EDGES);
  assign edge_flags[adcpm_pkg::FL_CONV]   = (edge_cnt >= CONV_EDGES);
  assign edge_flags[adcpm_pkg::FL_FULL]   = at_end;

endmodule : adcpm_link

/* logic/adcpm_sequencer.sv */
// Power mode sequencer top: link side counter and system side power state.
`timescale 1ns/10ps
module adcpm_sequencer #(
  parameter int   RES_BITS      = 12,
  parameter logic START_POWERED = adcpm_pkg::START_POWERED
) (
  input  wire logic                clk,               // System clock.
  input  wire logic                rst,               // Sync reset, high.
  input  wire logic                bit_clk,           // Serial bit clock.
  input  wire logic                frame_select_n,    // Frame select pin.
  input  wire logic [RES_BITS-1:0] conversion_result, // Result, bit clock.
  output logic                     serial_result_out, // Serial data bit.
  output logic                     serial_result_oe,  // Data pin enable.
  output logic                     analog_power_on,   // Analog supplies on.
  output logic                     fully_powered,     // Power-up complete.
  output logic                     track_mode,        // High: track.
  output logic                     conversion_start,  // Pulse: sample.
  output logic                     conversion_abort,  // Pulse: cut short.
  output logic                     conversion_done,   // Pulse: complete.
  output logic [1:0]               power_state        // Current state.
);

  ////////////////////////////////////////////////////////////////////////////

  logic [adcpm_pkg::FL_W-1:0] edge_flags;

  adcpm_link #(
    .RES_BITS          (RES_BITS)
  ) u_link (
    .bit_clk           (bit_clk),
    .frame_select_n    (frame_select_n),
    .conversion_result (conversion_result),
    .serial_result_out (serial_result_out),
    .serial_result_oe  (serial_result_oe),
    .edge_flags        (edge_flags)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Select level and frame flags brought onto the system clock.
  logic [adcpm_pkg::FL_W:0] sync_in;
  logic [adcpm_pkg::FL_W:0] sync_out;
  logic [adcpm_pkg::FL_W:0] sync_rst;

  assign sync_in  = {frame_select_n, edge_flags};
  assign sync_rst = {1'b1, {adcpm_pkg::FL_W{1'b0}}};

  adcpm_sync #(
    .WIDTH   (adcpm_pkg::FL_W + 1)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .rst_val (sync_rst),
    .d       (sync_in),
    .q       (sync_out)
  );

  logic                       select_n_s;
  logic [adcpm_pkg::FL_W-1:0] flags_s;
  logic                       select_n_q;
  logic                       sel_fall;
  logic                       sel_rise;
  logic                       frame_low;

  assign select_n_s = sync_out[adcpm_pkg::FL_W];
  assign flags_s    = sync_out[adcpm_pkg::FL_W-1:0];
  assign frame_low  = !select_n_s;
  assign sel_fall   = select_n_q && !select_n_s;
  assign sel_rise   = !select_n_q && select_n_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      select_n_q <= 1'b1;
    end else begin
      select_n_q <= select_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // The link clears its flags when select rises, so the system side keeps
  // every flag it saw during the frame and judges the release on that.
  logic [adcpm_pkg::FL_W-1:0] seen;
  logic [adcpm_pkg::FL_W-1:0] got;
  logic [adcpm_pkg::FL_W-1:0] next_seen;

  assign got       = seen | flags_s;
  assign next_seen = sel_fall ? flags_s :
                     (sel_rise ? '0 : (frame_low ? got : seen));

  always_ff @(posedge clk) begin
    if (rst) begin
      seen <= '0;
    end else begin
      seen <= next_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  adcpm_pkg::adcpm_state_t state;
  adcpm_pkg::adcpm_state_t next_state;
  adcpm_pkg::adcpm_state_t start_state;

  logic got_glitch;
  logic got_keep;
  logic got_conv;

  assign got_glitch  = got[adcpm_pkg::FL_GLITCH];
  assign got_keep    = got[adcpm_pkg::FL_KEEP];
  assign got_conv    = got[adcpm_pkg::FL_CONV];
  assign start_state = START_POWERED ? adcpm_pkg::PWR_NORMAL
                                     : adcpm_pkg::PWR_DOWN;

  always_comb begin
    next_state = state;
    case (state)
      adcpm_pkg::PWR_NORMAL: begin
        if (sel_rise && got_glitch && !got_keep) begin
          next_state = adcpm_pkg::PWR_DOWN;
        end else begin
          next_state = adcpm_pkg::PWR_NORMAL;
        end
      end
      adcpm_pkg::PWR_DOWN: begin
        if (sel_fall) begin
          next_state = adcpm_pkg::PWR_WAKE;
        end
      end
      adcpm_pkg::PWR_WAKE: begin
        if (sel_rise) begin
          next_state = got_keep ? adcpm_pkg::PWR_NORMAL
                                : adcpm_pkg::PWR_DOWN;
        end
      end
      default: begin
        next_state = adcpm_pkg::PWR_DOWN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= start_state;
    end else begin
      state <= next_state;
    end
  end

  assign power_state = state;

  ////////////////////////////////////////////////////////////////////////////

  // Power-up settle time counted from the wake-up select fall.
  logic [adcpm_pkg::SETTLE_W-1:0] settle_cnt;
  logic                           settle_done;
  logic                           next_fully;
  logic                           going_down;

  assign settle_done = (settle_cnt ==
                        adcpm_pkg::SETTLE_W'(adcpm_pkg::POWERUP_CYCLES));
  assign going_down  = (next_state == adcpm_pkg::PWR_DOWN);
  assign next_fully  = !going_down &&
                       (fully_powered || settle_done ||
                        got[adcpm_pkg::FL_FULL]);

  always_ff @(posedge clk) begin
    if (rst) begin
      settle_cnt <= '0;
    end else if (state == adcpm_pkg::PWR_DOWN) begin
      settle_cnt <= '0;
    end else if (!settle_done) begin
      settle_cnt <= settle_cnt + adcpm_pkg::SETTLE_W'(1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      analog_power_on <= START_POWERED;
      fully_powered   <= START_POWERED;
    end else begin
      analog_power_on <= !going_down;
      fully_powered   <= next_fully;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Track-and-hold: hold from select fall, back to track later in frame.
  logic back_to_track;
  logic next_track;

  assign back_to_track = (state == adcpm_pkg::PWR_WAKE) ?
                         got[adcpm_pkg::FL_FIRST] :
                         got[adcpm_pkg::FL_TRACK];
  assign next_track = sel_fall ? 1'b0 :
                      sel_rise ? !going_down :
                      (frame_low && back_to_track) ? 1'b1 : track_mode;

  always_ff @(posedge clk) begin
    if (rst) begin
      track_mode <= 1'b1;
    end else begin
      track_mode <= next_track;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  logic conv_running;
  logic next_running;

  assign next_running = sel_fall ? (state == adcpm_pkg::PWR_NORMAL) :
                        (sel_rise || got_conv) ? 1'b0 : conv_running;

  always_ff @(posedge clk) begin
    if (rst) begin
      conv_running     <= 1'b0;
      conversion_start <= 1'b0;
      conversion_abort <= 1'b0;
      conversion_done  <= 1'b0;
    end else begin
      conv_running     <= next_running;
      conversion_start <= sel_fall && (state == adcpm_pkg::PWR_NORMAL);
      conversion_abort <= conv_running && sel_rise && !got_conv;
      conversion_done  <= conv_running && got_conv;
    end
  end

endmodule : adcpm_sequencer

/* sim/adcpm_master.sv */
// Serial master model driving frame select and a framed bit clock.
`timescale 1ns/10ps
module adcpm_master (
  output logic      bit_clk,           // Still low outside frames.
  output logic      frame_select_n,    // Frame select.
  input  wire logic serial_result_out, // Data from the block.
  input  wire logic serial_result_oe   // Data enable.
);
  logic [15:0] rx_word; // Bits taken at rising edges.
  logic        oe_end;  // Enable just before release.
  // A select rise at start clears the link counter, which has no reset.
  initial begin
    bit_clk = 1'b0;
    frame_select_n = 1'b0;
    #1;
    frame_select_n = 1'b1;
  end
  // Frame of n bit clocks, a hold before release, then the quiet time.
  task automatic frame(input int n);
    rx_word = 16'h0000;
    frame_select_n = 1'b0;
    #5.3;
    for (int i = 0; i < n; i++) begin
      bit_clk = 1'b1;
      rx_word = {rx_word[14:0], serial_result_out};
      #3;
      bit_clk = 1'b0;
      #3;
    end
    #80;
    oe_end = serial_result_oe;
    frame_select_n = 1'b1;
    #100;
  endtask : frame
endmodule : adcpm_master

/* sim/adcpm_checker.sv */
// Port checker of the power mode sequencer.
`timescale 1ns/10ps
module adcpm_checker #(
  parameter int RES_BITS = 12
) (
  input wire logic                clk,               // System clock.
  input wire logic                rst,               // Reset.
  input wire logic                bit_clk,           // Link clock.
  input wire logic                frame_select_n,    // Frame select.
  input wire logic [RES_BITS-1:0] conversion_result, // Result.
  input wire logic                serial_result_out, // Serial data.
  input wire logic                serial_result_oe,  // Data enable.
  input wire logic                analog_power_on,   // Analog on.
  input wire logic                conversion_start,  // Start pulse.
  input wire logic [1:0]          power_state        // Power state.
);
  localparam logic [1:0] ST_N = adcpm_pkg::PWR_NORMAL;
  localparam logic [1:0] ST_D = adcpm_pkg::PWR_DOWN;
  localparam logic [1:0] ST_W = adcpm_pkg::PWR_WAKE;
  logic [4:0]  cnt;
  logic [15:0] word;
  logic        rise;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  assign word = 16'(conversion_result) << (12 - RES_BITS);
  always_ff @(negedge bit_clk or posedge frame_select_n) begin
    if (frame_select_n)
      cnt <= 5'h00;
    else if (cnt != 5'h10)
      cnt <= cnt + 5'h01;
  end
  always_ff @(posedge clk) begin
    rise <= frame_select_n;
  end
  ////////////////////////////////////////////////////////////////////////
  a_oe_idle_off: assert property (frame_select_n |-> !serial_result_oe)
    else $error("data enable high outside a frame");
  a_oe_in_frame: assert property
    (!frame_select_n && cnt < 5'h10 |-> serial_result_oe)
    else $error("data enable low inside a frame");
  a_oe_after_16: assert property (cnt == 5'h10 |-> !serial_result_oe)
    else $error("data enable high after the last edge");
  a_word_order: assert property (!frame_select_n && cnt < 5'h10
    |-> serial_result_out == word[4'hF - cnt[3:0]])
    else $error("serial bit out of order");
  a_down_judge: assert property ($rose(frame_select_n)
    && power_state == ST_N && $past(cnt) >= 5'h02 && $past(cnt) < 5'h0A
    |-> ##[1:6] power_state == ST_D)
    else $error("no power-down after mid release");
  a_keep_judge: assert property ($rose(frame_select_n)
    && power_state == ST_N && ($past(cnt) < 5'h02 || $past(cnt) >= 5'h0A)
    |-> ##1 (power_state == ST_N)[*6])
    else $error("left normal state");
  a_wake_fail: assert property ($rose(frame_select_n) && power_state == ST_W
    && $past(cnt) < 5'h0A |-> ##[1:6] power_state == ST_D)
    else $error("short wake frame did not return down");
  a_wake_ok: assert property ($rose(frame_select_n) && power_state == ST_W
    && $past(cnt) >= 5'h0A |-> ##[1:6] power_state == ST_N)
    else $error("long wake frame did not reach normal");
  a_wake_entry: assert property ($fell(frame_select_n) && power_state == ST_D
    |-> ##[1:6] (power_state == ST_W && analog_power_on))
    else $error("no wake on select fall");
  a_down_unpowered: assert property (power_state == ST_D |-> !analog_power_on)
    else $error("analog on while down");
  a_start_on_fall: assert property ($fell(frame_select_n) && power_state == ST_N
    |-> ##[1:5] conversion_start)
    else $error("no start after select fall");
  c_full: cover property (cnt == 5'h10);
  c_down: cover property (power_state == ST_D);
  c_wake: cover property (rise && power_state == ST_W);
endmodule : adcpm_checker
bind adcpm_sequencer adcpm_checker #(.RES_BITS(RES_BITS)) u_adcpm_checker (
  .clk, .rst, .bit_clk, .frame_select_n, .conversion_result,
  .serial_result_out, .serial_result_oe, .analog_power_on,
  .conversion_start, .power_state
);

/* sim/adc_power_mode_sequencer_test.sv */
// Self-checking bench of the power mode sequencer.
`timescale 1ns/10ps
`define CHK(what, want, got) \
  begin \
    cmp_count++; \
    if ((got) !== (want)) begin \
      failures++; \
      $display("ERROR %s expected %0h seen %0h", what, want, got); \
    end \
  end
module adc_power_mode_sequencer_test;
  localparam logic [1:0] ST_N = adcpm_pkg::PWR_NORMAL;
  localparam logic [1:0] ST_D = adcpm_pkg::PWR_DOWN;
  logic        clk, rst, bit_clk, frame_select_n;
  logic [11:0] conversion_result;
  logic        serial_result_out, serial_result_oe, analog_power_on;
  logic        fully_powered, track_mode, conversion_start;
  logic        conversion_abort, conversion_done;
  logic [1:0]  power_state;
  int          failures, cmp_count, cycles, n_start, n_abort, n_done;
  adcpm_sequencer u_adcpm_sequencer (
    .clk, .rst, .bit_clk, .frame_select_n, .conversion_result,
    .serial_result_out, .serial_result_oe, .analog_power_on,
    .fully_powered, .track_mode, .conversion_start, .conversion_abort,
    .conversion_done, .power_state
  );
  adcpm_master u_adcpm_master (
    .bit_clk, .frame_select_n, .serial_result_out, .serial_result_oe
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Pulses are counted on the falling edge, where they are settled.
  always @(negedge clk) begin
    cycles++;
    n_start += int'(conversion_start === 1'b1);
    n_abort += int'(conversion_abort === 1'b1);
    n_done += int'(conversion_done === 1'b1);
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic run(input int n, input logic [11:0] res);
    @(posedge clk);
    #1;
    conversion_result = res;
    u_adcpm_master.frame(n);
    repeat (3) @(posedge clk);
    #1;
  endtask : run
  task automatic t_full_frame;
    int s, d;
    s = n_start;
    d = n_done;
    run(16, 12'hA5C);
    `CHK("word", 16'h0A5C, u_adcpm_master.rx_word)
    `CHK("enable at end", 1'b0, u_adcpm_master.oe_end)
    `CHK("start", s + 1, n_start)
    `CHK("done", d + 1, n_done)
    `CHK("state", ST_N, power_state)
  endtask : t_full_frame
  task automatic t_abort_keep;
    int a;
    a = n_abort;
    run(12, 12'h6B3);
    `CHK("short word", 16'h006B, u_adcpm_master.rx_word)
    `CHK("abort", a + 1, n_abort)
    `CHK("state", ST_N, power_state)
    `CHK("power", 1'b1, analog_power_on)
  endtask : t_abort_keep
  task automatic t_release_table;
    int         edges [4] = '{1, 2, 9, 10};
    logic [1:0] want [4] = '{ST_N, ST_D, ST_D, ST_N};
    for (int i = 0; i < 4; i++) begin
      run(edges[i], 12'hFFF);
      `CHK("state", want[i], power_state)
      `CHK("power", want[i] != ST_D, analog_power_on)
      `CHK("hold", want[i] != ST_D, track_mode)
      if (want[i] == ST_D) begin
        run(16, 12'h001);
        `CHK("woken state", ST_N, power_state)
        `CHK("full", 1'b1, fully_powered)
      end
    end
  endtask : t_release_table
  task automatic t_wake;
    run(3, 12'h123);
    `CHK("state", ST_D, power_state)
    run(9, 12'h123);
    `CHK("short wake", ST_D, power_state)
    run(10, 12'h123);
    `CHK("wake", ST_N, power_state)
    `CHK("track", 1'b1, track_mode)
    `CHK("not yet full", 1'b0, fully_powered)
    repeat (50) @(posedge clk);
    #1;
    `CHK("full", 1'b1, fully_powered)
  endtask : t_wake
  initial begin
    rst = 1'b1;
    conversion_result = 12'h000;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("reset state", ST_N, power_state)
    `CHK("reset track", 1'b1, track_mode)
    t_full_frame();
    t_abort_keep();
    t_release_table();
    t_wake();
    conclude();
  end
endmodule : adc_power_mode_sequencer_test
